// >>> src/crd_pkg.sv
// constants, types and helpers shared by the clock request distributor
package crd_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int KEY_WINDOW_NS = 16;
  // longest time: round down, never below one cycle
  localparam int KEY_WINDOW_CYC = (KEY_WINDOW_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                  (KEY_WINDOW_NS / CLK_PERIOD_NS);
  localparam int KEY_CNT_W = 4;
  localparam int NSRC = 5;
  localparam int SRC_W = 3;
  localparam int DIV_W = 6;
  localparam int EDGE_COUNT_DEFAULT = 4;
  localparam int EDGE_CNT_W = 8;
  // value is arbitrary
  localparam logic [7:0] KEY_DEFAULT = 8'hA5;
  localparam logic [DIV_W-1:0] DIV_RESET = 6'h00;
  localparam int PLL_MAX_MHZ = 48;
  localparam int PLL_MIN_REF_MHZ = 16;
  localparam logic [1:0] MUL_OFF = 2'h0;
  localparam logic [1:0] MUL_X2 = 2'h2;
  localparam logic [1:0] MUL_X3 = 2'h3;
  localparam logic [1:0] TCD_SRC_HF = 2'h0;
  localparam logic [1:0] TCD_SRC_PLL = 2'h1;
  localparam logic [1:0] TCD_SRC_EXT = 2'h2;
  localparam logic RTC_SRC_LP = 1'b0;
  localparam logic RTC_SRC_XT = 1'b1;

  typedef enum logic [2:0] {
    SRC_HF = 3'h0,
    SRC_LP = 3'h1,
    SRC_XT32 = 3'h2,
    SRC_EXT = 3'h3,
    SRC_PLL = 3'h4
  } crd_src_t;

  typedef enum logic [1:0] {
    SLP_ACTIVE = 2'h0,
    SLP_IDLE = 2'h1,
    SLP_STANDBY = 2'h2,
    SLP_PDOWN = 2'h3
  } crd_sleep_t;

  typedef enum logic [1:0] {
    SW_IDLE = 2'h0,
    SW_COUNT = 2'h1,
    SW_SYNC = 2'h2,
    SW_ALIGN = 2'h3
  } crd_sw_t;

  function automatic logic [NSRC-1:0] crd_onehot(input logic [SRC_W-1:0] s);
    logic [NSRC-1:0] r;
    r = '0;
    if (s < SRC_W'(NSRC)) begin
      r[s] = 1'b1;
    end
    return r;
  endfunction

  function automatic logic crd_is_external(input logic [SRC_W-1:0] s);
    return (s == SRC_XT32) || (s == SRC_EXT);
  endfunction
endpackage

// >>> src/crd_presc_if.sv
// link between the source selector and the prescaler
`timescale 1ns/10ps
interface crd_presc_if #(parameter int DIV_W = 6);
  logic tick;
  logic [DIV_W-1:0] div;
  logic div_en;
  logic div_level;
  modport ctrl (output tick, output div, input div_en, input div_level);
  modport presc (input tick, input div, output div_en, output div_level);
endinterface

// >>> src/crd_prescaler.sv
// main clock prescaler: divides main clock ticks by div+1
`timescale 1ns/10ps
module crd_prescaler
  import crd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  crd_presc_if.presc p
);
  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] div_act_reg;
  logic en_reg;
  logic level_reg;
  logic wrap;

  assign wrap = (cnt_reg == div_act_reg);

  // new factor is only loaded at the period boundary, so no short pulse
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_reg <= '0;
      div_act_reg <= DIV_RESET;
    end else if (i_ce && p.tick) begin
      if (wrap) begin
        cnt_reg <= '0;
        div_act_reg <= p.div;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  // one output tick per div+1 input ticks, factor 1 to 64
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      en_reg <= 1'b0;
      level_reg <= 1'b0;
    end else if (i_ce) begin
      en_reg <= p.tick && wrap;
      if (p.tick && wrap) begin
        level_reg <= ~level_reg;
      end
    end
  end

  assign p.div_en = en_reg;
  assign p.div_level = level_reg;
endmodule

// >>> src/crd_top.sv
// clock request distributor: source select, protected switching, prescale, requests
//
// Behaviour
// - route each request to its configured source
// - main clock runs active/idle, standby on request
// - core clock from prescaled main, to CPU/NVM
// - peripheral clock from prescaled main, optional pin
// - any source may drive the main clock
// - calendar clock requested when enabled; source change disabled-only
// - watchdog clock requested whenever watchdog enabled
// - brownout clock in sampled mode; fuse picks alternative
// - timer D clock requested when enabled, except on PLL with the multiplier off; source locked
// - source select field chooses the main source
// - prescaler divides by one to sixty-four
// - multiplier x2 or x3, output at most 48 MHz
// - source switching never produces short main pulses
// - external switch needs edges; stuck until reset
// - switch-in-progress flag while switching
// - reset source from fuse: high-frequency or low-power
`timescale 1ns/10ps
module crd_top
  import crd_pkg::*;
#(
  parameter int EDGE_COUNT = EDGE_COUNT_DEFAULT,
  parameter logic [7:0] PROT_KEY = KEY_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [NSRC-1:0] i_src_level,
  input wire logic i_fuse_lp_select,
  input wire logic i_fuse_bod_alt,
  input wire logic i_key_wr,
  input wire logic [7:0] i_key_data,
  input wire logic i_ctrl_wr,
  input wire logic [SRC_W-1:0] i_source_select_field,
  input wire logic [DIV_W-1:0] i_presc_div,
  input wire logic i_clock_output_pin_en,
  input wire logic [1:0] i_sleep_mode,
  input wire logic i_main_req,
  input wire logic i_rtc_en,
  input wire logic i_rtc_src,
  input wire logic i_wdt_en,
  input wire logic i_bod_en,
  input wire logic i_bod_sampled,
  input wire logic i_tcd_en,
  input wire logic [1:0] i_tcd_src,
  input wire logic i_pll_wr,
  input wire logic [1:0] i_pll_mul,
  input wire logic [5:0] i_pll_ref_mhz,
  output logic [NSRC-1:0] o_osc_req,
  output logic [SRC_W-1:0] o_main_src,
  output logic o_switch_in_progress_flag,
  output logic o_switch_blocked,
  output logic [DIV_W-1:0] o_presc_div,
  output logic o_core_clk_en,
  output logic o_peripheral_clock_en,
  output logic o_clock_output_pin,
  output logic o_clock_output_pin_oe_n,
  output logic o_rtc_clk,
  output logic o_watchdog_clock,
  output logic o_brownout_clock,
  output logic o_timer_type_d_clock,
  output logic [1:0] o_pll_mul
);
  crd_presc_if #(.DIV_W(DIV_W)) presc_if ();

  logic [NSRC-1:0] prev_reg;
  logic [NSRC-1:0] edges;
  logic boot_reg;
  logic [SRC_W-1:0] cur_src_reg;
  logic [SRC_W-1:0] new_src_reg;
  crd_sw_t sw_reg;
  logic [EDGE_CNT_W-1:0] edge_cnt_reg;
  logic [KEY_CNT_W-1:0] key_cnt_reg;
  logic [DIV_W-1:0] div_reg;
  logic main_run;
  logic raw_tick;
  logic new_edge;
  logic key_open;
  logic sel_ok;
  logic ctrl_take;
  logic rtc_src_reg;
  logic [1:0] tcd_src_reg;
  logic bod_alt_reg;
  logic [1:0] pll_mul_reg;
  logic pll_ok;
  logic rtc_clk_reg;
  logic wdt_clk_reg;
  logic bod_clk_reg;
  logic tcd_clk_reg;
  logic core_en_reg;
  logic per_en_reg;
  logic pin_reg;
  logic pin_oe_n_reg;
  logic [NSRC-1:0] req_reg;
  logic [NSRC-1:0] req_next;
  logic [SRC_W-1:0] tcd_src_idx;
  logic [SRC_W-1:0] bod_src_idx;
  logic [SRC_W-1:0] rtc_src_idx;
  logic [7:0] pll_out_mhz;

  // rising edges of every source, sampled on the system clock
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      prev_reg <= '0;
    end else if (i_ce) begin
      prev_reg <= i_src_level;
    end
  end
  assign edges = i_src_level & ~prev_reg;

  assign main_run = (i_sleep_mode == SLP_ACTIVE) || (i_sleep_mode == SLP_IDLE) ||
                    ((i_sleep_mode == SLP_STANDBY) && i_main_req);
  assign raw_tick = |(edges & crd_onehot(cur_src_reg));
  assign new_edge = |(edges & crd_onehot(new_src_reg));

  // protection window opened by the key, closed by any control write
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      key_cnt_reg <= '0;
    end else if (i_ce) begin
      if (i_key_wr && (i_key_data == PROT_KEY)) begin
        key_cnt_reg <= KEY_CNT_W'(KEY_WINDOW_CYC);
      end else if (i_ctrl_wr) begin
        key_cnt_reg <= '0;
      end else if (key_cnt_reg != '0) begin
        key_cnt_reg <= key_cnt_reg - 1'b1;
      end
    end
  end
  assign key_open = (key_cnt_reg != '0);
  assign sel_ok = (i_source_select_field < SRC_W'(NSRC));
  assign ctrl_take = i_ctrl_wr && key_open && !boot_reg;

  // prescaler factor shares the protected control write
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      div_reg <= DIV_RESET;
    end else if (i_ce && ctrl_take) begin
      div_reg <= i_presc_div;
    end
  end

  // source switch sequencer; a busy switch refuses new selections
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      boot_reg <= 1'b1;
      cur_src_reg <= SRC_HF;
      new_src_reg <= SRC_HF;
      sw_reg <= SW_IDLE;
      edge_cnt_reg <= '0;
    end else if (i_ce) begin
      boot_reg <= 1'b0;
      if (boot_reg) begin
        // fuse is caught just after reset release
        cur_src_reg <= i_fuse_lp_select ? SRC_LP : SRC_HF;
        new_src_reg <= i_fuse_lp_select ? SRC_LP : SRC_HF;
      end else begin
        case (sw_reg)
          SW_IDLE: begin
            if (ctrl_take && sel_ok && (i_source_select_field != cur_src_reg)) begin
              new_src_reg <= i_source_select_field;
              edge_cnt_reg <= '0;
              sw_reg <= SW_COUNT;
            end
          end
          SW_COUNT: begin
            // no timeout: a dead external source keeps us here until reset
            if (new_edge) begin
              if (edge_cnt_reg == EDGE_CNT_W'(EDGE_COUNT - 1)) begin
                sw_reg <= SW_SYNC;
              end else begin
                edge_cnt_reg <= edge_cnt_reg + 1'b1;
              end
            end
          end
          SW_SYNC: begin
            // finish the old source's period before letting go of it
            if (raw_tick) begin
              sw_reg <= SW_ALIGN;
            end
          end
          SW_ALIGN: begin
            // first new edge ends the switch; main ticks start at the next new edge
            if (new_edge) begin
              cur_src_reg <= new_src_reg;
              sw_reg <= SW_IDLE;
            end
          end
          default: begin
            sw_reg <= SW_IDLE;
          end
        endcase
      end
    end
  end

  // ticks are suppressed during ALIGN so no short period escapes
  assign presc_if.tick = raw_tick && main_run && (sw_reg != SW_ALIGN) && !boot_reg;
  assign presc_if.div = div_reg;

  crd_prescaler u_presc (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .p(presc_if.presc)
  );

  // core clock stops in idle, peripheral clock keeps running
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      core_en_reg <= 1'b0;
      per_en_reg <= 1'b0;
      pin_reg <= 1'b0;
      pin_oe_n_reg <= 1'b1;
    end else if (i_ce) begin
      core_en_reg <= presc_if.div_en && (i_sleep_mode == SLP_ACTIVE);
      per_en_reg <= presc_if.div_en;
      pin_reg <= i_clock_output_pin_en && presc_if.div_level;
      pin_oe_n_reg <= !i_clock_output_pin_en;
    end
  end

  // asynchronous clock sources may only change while their user is off
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rtc_src_reg <= RTC_SRC_LP;
      tcd_src_reg <= TCD_SRC_HF;
    end else if (i_ce) begin
      if (!i_rtc_en) begin
        rtc_src_reg <= i_rtc_src;
      end
      if (!i_tcd_en && (i_tcd_src != 2'h3)) begin
        tcd_src_reg <= i_tcd_src;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      bod_alt_reg <= 1'b0;
    end else if (i_ce && boot_reg) begin
      bod_alt_reg <= i_fuse_bod_alt;
    end
  end

  // multiplier accepted only for a fast enough reference and legal result
  assign pll_out_mhz = (i_pll_mul == MUL_X3) ? 8'(i_pll_ref_mhz) * 8'h03 :
                       8'(i_pll_ref_mhz) * 8'h02;
  assign pll_ok = (i_pll_mul == MUL_OFF) ||
                  (((i_pll_mul == MUL_X2) || (i_pll_mul == MUL_X3)) &&
                   (8'(i_pll_ref_mhz) >= 8'(PLL_MIN_REF_MHZ)) &&
                   (pll_out_mhz <= 8'(PLL_MAX_MHZ)));

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pll_mul_reg <= MUL_OFF;
    end else if (i_ce && i_pll_wr && pll_ok) begin
      pll_mul_reg <= i_pll_mul;
    end
  end

  assign rtc_src_idx = (rtc_src_reg == RTC_SRC_XT) ? SRC_XT32 : SRC_LP;
  assign bod_src_idx = bod_alt_reg ? SRC_XT32 : SRC_LP;
  assign tcd_src_idx = (tcd_src_reg == TCD_SRC_PLL) ? SRC_PLL :
                       (tcd_src_reg == TCD_SRC_EXT) ? SRC_EXT : SRC_HF;

  // requests from users are steered onto the owning oscillator
  always_comb begin
    req_next = '0;
    if (main_run || (sw_reg == SW_SYNC)) begin
      req_next = req_next | crd_onehot(cur_src_reg);
    end
    if (sw_reg != SW_IDLE) begin
      req_next = req_next | crd_onehot(new_src_reg);
    end
    if (i_rtc_en) begin
      req_next = req_next | crd_onehot(rtc_src_idx);
    end
    if (i_wdt_en) begin
      req_next = req_next | crd_onehot(SRC_LP);
    end
    if (i_bod_en && i_bod_sampled) begin
      req_next = req_next | crd_onehot(bod_src_idx);
    end
    if (i_tcd_en) begin
      req_next = req_next | crd_onehot(tcd_src_idx);
    end
    if (pll_mul_reg == MUL_OFF) begin
      req_next[SRC_PLL] = 1'b0;
    end
  end

  // routed clock levels, registered to keep outputs glitch free
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      req_reg <= '0;
      rtc_clk_reg <= 1'b0;
      wdt_clk_reg <= 1'b0;
      bod_clk_reg <= 1'b0;
      tcd_clk_reg <= 1'b0;
    end else if (i_ce) begin
      req_reg <= req_next;
      rtc_clk_reg <= i_rtc_en && i_src_level[rtc_src_idx];
      wdt_clk_reg <= i_wdt_en && i_src_level[SRC_LP];
      bod_clk_reg <= i_bod_en && i_bod_sampled && i_src_level[bod_src_idx];
      tcd_clk_reg <= i_tcd_en && i_src_level[tcd_src_idx];
    end
  end

  assign o_osc_req = req_reg;
  assign o_main_src = cur_src_reg;
  assign o_switch_in_progress_flag = (sw_reg != SW_IDLE);
  assign o_switch_blocked = (sw_reg == SW_COUNT) && crd_is_external(new_src_reg);
  assign o_presc_div = div_reg;
  assign o_core_clk_en = core_en_reg;
  assign o_peripheral_clock_en = per_en_reg;
  assign o_clock_output_pin = pin_reg;
  assign o_clock_output_pin_oe_n = pin_oe_n_reg;
  assign o_rtc_clk = rtc_clk_reg;
  assign o_watchdog_clock = wdt_clk_reg;
  assign o_brownout_clock = bod_clk_reg;
  assign o_timer_type_d_clock = tcd_clk_reg;
  assign o_pll_mul = pll_mul_reg;
endmodule

// >>> dv/crd_sva.sv
// port assertions for the clock request distributor
`timescale 1ns/10ps
module crd_sva
  import crd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [1:0] i_sleep_mode,
  input wire logic i_wdt_en,
  input wire logic i_bod_en,
  input wire logic i_bod_sampled,
  input wire logic i_tcd_en,
  input wire logic i_clock_output_pin_en,
  input wire logic [NSRC-1:0] o_osc_req,
  input wire logic [SRC_W-1:0] o_main_src,
  input wire logic o_switch_in_progress_flag,
  input wire logic o_switch_blocked,
  input wire logic o_core_clk_en,
  input wire logic o_peripheral_clock_en,
  input wire logic o_clock_output_pin,
  input wire logic o_clock_output_pin_oe_n,
  input wire logic o_watchdog_clock,
  input wire logic o_brownout_clock,
  input wire logic o_timer_type_d_clock
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // four cycles let ticks already in the two-stage pipeline drain
  chk_core_sleep: assert property ((i_sleep_mode != SLP_ACTIVE)[*4] |-> !o_core_clk_en)
    else $error("core tick while not active");
  chk_pdown_quiet: assert property (
    (i_sleep_mode == SLP_PDOWN)[*4] |-> !o_peripheral_clock_en)
    else $error("peripheral tick in power down");
  chk_wdt_req: assert property (i_wdt_en |=> o_osc_req[SRC_LP])
    else $error("watchdog source not requested");
  chk_wdt_gate: assert property (!i_wdt_en |=> !o_watchdog_clock)
    else $error("watchdog clock while off");
  chk_bod_gate: assert property (!(i_bod_en && i_bod_sampled) |=> !o_brownout_clock)
    else $error("brownout clock outside sampled mode");
  chk_tcd_gate: assert property (!i_tcd_en |=> !o_timer_type_d_clock)
    else $error("timer clock while off");
  chk_pin_off: assert property (
    (!i_clock_output_pin_en)[*2] |-> o_clock_output_pin_oe_n && !o_clock_output_pin)
    else $error("clock pin active while disabled");
  // while edges are still missing the main source must not move
  chk_blocked_flag: assert property (
    o_switch_blocked |=> o_switch_in_progress_flag && $stable(o_main_src))
    else $error("main source moved while switch blocked");
endmodule

bind crd_top crd_sva crd_sva_i (.i_clk, .i_sys_rst, .i_sleep_mode, .i_wdt_en, .i_bod_en,
  .i_bod_sampled, .i_tcd_en, .i_clock_output_pin_en, .o_osc_req, .o_main_src, .o_switch_in_progress_flag,
  .o_switch_blocked, .o_core_clk_en, .o_peripheral_clock_en, .o_clock_output_pin,
  .o_clock_output_pin_oe_n, .o_watchdog_clock, .o_brownout_clock, .o_timer_type_d_clock);

// >>> dv/crd_osc_model.sv
// oscillator model: free running source levels, the external one can stop
`timescale 1ns/10ps
module crd_osc_model
  import crd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_ext_dead,
  output logic [NSRC-1:0] o_src_level
);
  // half periods in system cycles, short so that switches settle fast
  localparam int HALF [NSRC] = '{1, 8, 6, 2, 1};
  int cnt [NSRC] = '{default: 0};
  initial o_src_level = '0;
  always @(posedge i_clk) begin
    #1;
    for (int k = 0; k < NSRC; k++) begin
      cnt[k] = cnt[k] + 1;
      if (cnt[k] >= HALF[k]) begin
        cnt[k] = 0;
        o_src_level[k] = (k == SRC_EXT && i_ext_dead) ? 1'b0 : !o_src_level[k];
      end
    end
  end
endmodule

// >>> dv/tb_crd_top.sv
// self-checking bench for the clock request distributor
`timescale 1ns/10ps
module tb_crd_top
  import crd_pkg::*;
;
  // value is arbitrary
  localparam logic [7:0] KEY = 8'h3C;
  localparam logic [9:0] PLL_TAB [6] = '{{2'h2, 6'h10, 2'h2}, {2'h3, 6'h11, 2'h2},
    {2'h3, 6'h10, 2'h3}, {2'h2, 6'h0F, 2'h3}, {2'h0, 6'h00, 2'h0}, {2'h3, 6'h10, 2'h3}};
  localparam logic [2:0] SW_SEQ [5] = '{SRC_LP, SRC_XT32, SRC_EXT, SRC_PLL, SRC_HF};
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_fuse_lp_select = 1'b0, i_fuse_bod_alt = 1'b0;
  logic i_key_wr = 1'b0, i_ctrl_wr = 1'b0, i_clock_output_pin_en = 1'b0, i_main_req = 1'b0;
  logic i_rtc_en = 1'b0, i_rtc_src = 1'b0, i_wdt_en = 1'b0, i_bod_en = 1'b0;
  logic i_bod_sampled = 1'b0, i_tcd_en = 1'b0, i_pll_wr = 1'b0, ext_dead = 1'b0;
  logic [7:0] i_key_data = 8'h00;
  logic [5:0] i_presc_div = 6'h00, i_pll_ref_mhz = 6'h00;
  logic [1:0] i_sleep_mode = 2'h0, i_tcd_src = 2'h0, i_pll_mul = 2'h0, exp_mul = 2'h0;
  logic [2:0] i_source_select_field = 3'h0, cur = 3'h0, o_main_src;
  logic [4:0] i_src_level, o_osc_req, src_q;
  logic [5:0] o_presc_div;
  logic [1:0] o_pll_mul;
  logic o_switch_in_progress_flag, o_switch_blocked, o_core_clk_en, o_peripheral_clock_en;
  logic o_clock_output_pin, o_clock_output_pin_oe_n, o_rtc_clk, o_watchdog_clock;
  logic o_brownout_clock, o_timer_type_d_clock, pin_q;
  logic [7:0] per_cnt, core_cnt, tog_cnt;
  int err_count = 0, compares = 0;
  logic rsrc = 1'b0;
  logic [1:0] tsrc = 2'h0;
  logic [2:0] bidx = 3'h0;

  always #2 i_clk = !i_clk;
  always @(posedge i_clk) begin
    src_q <= i_src_level;
    pin_q <= o_clock_output_pin;
    per_cnt <= per_cnt + 8'(o_peripheral_clock_en === 1'b1);
    core_cnt <= core_cnt + 8'(o_core_clk_en === 1'b1);
    tog_cnt <= tog_cnt + 8'(o_clock_output_pin !== pin_q);
  end

  crd_osc_model crd_osc_model_i (.i_clk, .i_ext_dead(ext_dead), .o_src_level(i_src_level));
  crd_top #(.EDGE_COUNT(2), .PROT_KEY(KEY)) crd_top_i (.i_clk, .i_sys_rst, .i_ce(1'b1),
    .i_src_level, .i_fuse_lp_select, .i_fuse_bod_alt, .i_key_wr, .i_key_data, .i_ctrl_wr,
    .i_source_select_field, .i_presc_div, .i_clock_output_pin_en, .i_sleep_mode, .i_main_req,
    .i_rtc_en, .i_rtc_src, .i_wdt_en, .i_bod_en, .i_bod_sampled, .i_tcd_en, .i_tcd_src,
    .i_pll_wr, .i_pll_mul, .i_pll_ref_mhz, .o_osc_req, .o_main_src,
    .o_switch_in_progress_flag, .o_switch_blocked, .o_presc_div, .o_core_clk_en,
    .o_peripheral_clock_en, .o_clock_output_pin, .o_clock_output_pin_oe_n, .o_rtc_clk,
    .o_watchdog_clock, .o_brownout_clock, .o_timer_type_d_clock, .o_pll_mul);

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (exp !== got) begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic lp);
    i_fuse_lp_select = lp;
    i_sys_rst = 1'b1;
    step(2);
    i_sys_rst = 1'b0;
    step(3);
  endtask
  task automatic prot_wr(input logic [7:0] key, input logic [2:0] s, input logic [5:0] d);
    i_key_wr = 1'b1;
    i_key_data = key;
    step(1);
    i_key_wr = 1'b0;
    i_ctrl_wr = 1'b1;
    i_source_select_field = s;
    i_presc_div = d;
    step(1);
    i_ctrl_wr = 1'b0;
    step(1);
  endtask
  task automatic switch_to(input logic [2:0] s);
    int n;
    prot_wr(KEY, s, 6'h00);
    check("switch flag", 8'h01, o_switch_in_progress_flag);
    n = 0;
    while (o_switch_in_progress_flag !== 1'b0 && n < 200) begin
      step(1);
      n++;
    end
    step(1);
    cur = s;
    check("main source", cur, o_main_src);
  endtask
  function automatic logic [7:0] exp_ticks(input logic [1:0] m, input logic rq, input logic c);
    if (c) return (m == SLP_ACTIVE) ? 8'h08 : 8'h00;
    return (m != SLP_PDOWN && (m != SLP_STANDBY || rq)) ? 8'h08 : 8'h00;
  endfunction
  function automatic logic [2:0] tcd_idx(input logic [1:0] t);
    return (t == TCD_SRC_HF) ? SRC_HF : (t == TCD_SRC_PLL) ? SRC_PLL : SRC_EXT;
  endfunction
  // expectation uses the source that stood while the user was off
  function automatic logic [4:0] exp_req();
    logic [4:0] r;
    r = 5'h00;
    r[cur] = 1'b1;
    if (i_rtc_en) r[rsrc ? SRC_XT32 : SRC_LP] = 1'b1;
    if (i_wdt_en) r[SRC_LP] = 1'b1;
    if (i_bod_en && i_bod_sampled) r[bidx] = 1'b1;
    if (i_tcd_en) r[tcd_idx(tsrc)] = 1'b1;
    if (exp_mul == MUL_OFF) r[SRC_PLL] = 1'b0;
    return r;
  endfunction
  // the source ticks every 2 cycles, so a window of 8 periods holds exactly 8 ticks
  task automatic tick_test(input logic [5:0] d, input logic [1:0] m, input logic rq);
    i_sleep_mode = m;
    i_main_req = rq;
    prot_wr(KEY, cur, d);
    check("divider", d, o_presc_div);
    step(300);
    per_cnt = 8'h00;
    core_cnt = 8'h00;
    tog_cnt = 8'h00;
    step(16 * (int'(d) + 1));
    check("peripheral ticks", exp_ticks(m, rq, 1'b0), per_cnt);
    check("core ticks", exp_ticks(m, rq, 1'b1), core_cnt);
    check("pin toggles", i_clock_output_pin_en ? exp_ticks(m, rq, 1'b0) : 8'h00, tog_cnt);
    check("pin drive", !i_clock_output_pin_en, o_clock_output_pin_oe_n);
    check("main request", exp_ticks(m, rq, 1'b0) != 8'h00, o_osc_req[cur]);
  endtask

  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h7560256f));
    i_fuse_bod_alt = 1'($urandom);
    bidx = i_fuse_bod_alt ? SRC_XT32 : SRC_LP;
    do_reset(1'b0);
    check("boot source", SRC_HF, o_main_src);
    foreach (PLL_TAB[k]) begin
      {i_pll_mul, i_pll_ref_mhz, exp_mul} = PLL_TAB[k];
      i_pll_wr = 1'b1;
      step(1);
      i_pll_wr = 1'b0;
      step(1);
      check("multiplier", exp_mul, o_pll_mul);
    end
    // sources only change while the requester is off
    for (int k = 0; k < 12; k++) begin
      {i_rtc_en, i_wdt_en, i_bod_en, i_tcd_en} = 4'h0;
      {i_rtc_src, i_bod_sampled} = 2'($urandom);
      i_tcd_src = 2'($urandom % 3);
      step(2);
      rsrc = i_rtc_src;
      tsrc = i_tcd_src;
      {i_rtc_en, i_wdt_en, i_bod_en, i_tcd_en} = 4'($urandom);
      // a source change while the user runs must not reach the routing
      if (i_rtc_en) i_rtc_src = !i_rtc_src;
      if (i_tcd_en) i_tcd_src = 2'((i_tcd_src + 2'h1) % 3);
      step(3);
      check("requests", exp_req(), o_osc_req);
      check("watchdog clock", i_wdt_en & src_q[SRC_LP], o_watchdog_clock);
      check("rtc clock", i_rtc_en & src_q[rsrc ? SRC_XT32 : SRC_LP], o_rtc_clk);
      check("bod clock", i_bod_en & i_bod_sampled & src_q[bidx], o_brownout_clock);
      check("timer clock", i_tcd_en & src_q[tcd_idx(tsrc)], o_timer_type_d_clock);
    end
    {i_rtc_en, i_wdt_en, i_bod_en, i_tcd_en} = 4'h0;
    foreach (SW_SEQ[k]) switch_to(SW_SEQ[k]);
    prot_wr(~KEY, SRC_LP, 6'h05);
    check("source without key", cur, o_main_src);
    check("divider without key", 8'h00, o_presc_div);
    prot_wr(KEY, 3'h5 + 3'($urandom % 3), 6'h07);
    check("source bad code", cur, o_main_src);
    check("divider bad code", 8'h07, o_presc_div);
    for (int k = 0; k < 10; k++) begin
      i_clock_output_pin_en = 1'($urandom);
      tick_test(k == 0 ? 6'h3F : k == 1 ? 6'h00 : 6'($urandom % 8), 2'(k % 4), 1'(k / 4));
    end
    i_sleep_mode = SLP_ACTIVE;
    ext_dead = 1'b1;
    prot_wr(KEY, SRC_EXT, 6'h00);
    step(40);
    check("stuck switch", 8'h03, {o_switch_in_progress_flag, o_switch_blocked});
    prot_wr(KEY, SRC_LP, 6'h00);
    step(60);
    check("stuck source", SRC_HF, o_main_src);
    ext_dead = 1'b0;
    do_reset(1'b1);
    check("boot source low power", SRC_LP, o_main_src);
    report_and_stop();
  end
endmodule
